// file: core/mmap_pkg.sv
`default_nettype none
package mmap_pkg;
    // ****************************************************************
    // memory organisation
    // ****************************************************************
    localparam int          MEM_BYTES    = 640;
    localparam int          IDX_W        = 10;
    localparam logic [9:0]  BASE_AUX     = 10'h000;
    localparam logic [9:0]  BASE_MAIN    = 10'h080;
    localparam logic [9:0]  BASE_T1      = 10'h100;
    localparam logic [9:0]  BASE_T2      = 10'h180;
    localparam logic [9:0]  BASE_T3      = 10'h200;

    // ****************************************************************
    // slave addresses and byte locations
    // ****************************************************************
    localparam logic [7:0]  AUX_DEV_ADDR   = 8'hA0;
    localparam logic [7:0]  MAIN_DEV_ADDR  = 8'hA2;
    localparam logic [7:0]  UPPER_START    = 8'h80;
    localparam logic [7:0]  RSVD_FIRST     = 8'h28;
    localparam logic [7:0]  RSVD_LAST      = 8'h37;
    localparam logic [7:0]  MEAS_FIRST     = 8'h60;
    localparam logic [7:0]  MEAS_LAST      = 8'h6F;
    localparam logic [6:0]  MEAS_TEMP      = 7'h60;
    localparam logic [6:0]  MEAS_VCC       = 7'h62;
    localparam logic [6:0]  MEAS_MON_A     = 7'h64;
    localparam logic [6:0]  MEAS_MON_B     = 7'h66;
    localparam logic [6:0]  MEAS_MON_C     = 7'h68;
    localparam logic [6:0]  TABLE_SEL      = 7'h7F;
    localparam logic [6:0]  MAN_WIPER0     = 7'h02;
    localparam logic [6:0]  MAN_WIPER1     = 7'h03;
    localparam logic [6:0]  CFG_BYTE       = 7'h09;
    localparam logic [6:0]  MAIN_ADDR_BYTE = 7'h0C;
    localparam logic [7:0]  READ_FILL      = 8'hFF;

    // configuration byte fields and reset values
    localparam int          CFG_TEN      = 0;
    localparam int          CFG_SINGLE_ADDRESS_SELECT     = 1;
    localparam int          CFG_PROGRAMMABLE_MAIN_ADDR_SELECT    = 2;
    localparam int          CFG_MAIN_SPACE_PROTECT_ENABLE     = 3;
    localparam int          CFG_AUX_SPACE_PROTECT_ENABLE     = 4;
    localparam logic [7:0]  CFG_RESET    = 8'h01;
    localparam logic [7:0]  CFG_MASK     = 8'h1F;

    // ****************************************************************
    // temperature look-up index
    // ****************************************************************
    localparam logic [7:0]  LUT_FIRST    = 8'h80;
    localparam logic [7:0]  LUT_LAST     = 8'hC7;
    localparam logic signed [8:0] TEMP_MIN_C = 9'sh1D8;
    localparam logic signed [8:0] TEMP_MAX_C = 9'sh066;

    // ****************************************************************
    // wishbone register map
    // ****************************************************************
    localparam logic [7:0]  WB_CONFIG    = 8'h00;
    localparam logic [7:0]  WB_STATUS    = 8'h04;
    localparam logic [7:0]  WB_ADDRS     = 8'h08;
    localparam logic [7:0]  WB_TEMP      = 8'h0C;

    typedef enum logic [1:0] {
        MMAP_OP_ADDR,
        MMAP_OP_PTR,
        MMAP_OP_WRITE,
        MMAP_OP_READ
    } mmap_op_e;

    typedef struct packed {
        logic       valid;
        mmap_op_e   op;
        logic [7:0] data;
    } mmap_ser_req_s;

    typedef struct packed {
        logic       done;
        logic       match;
        logic       wr_ok;
        logic [7:0] rdata;
    } mmap_ser_rsp_s;

    typedef struct packed {
        logic        valid;
        logic [11:0] temp;
        logic [11:0] vcc;
        logic [11:0] mon_a;
        logic [11:0] mon_b;
        logic [11:0] mon_c;
    } mmap_meas_s;
endpackage
`default_nettype wire

// file: core/mmap_temp_index.sv
`default_nettype none
module mmap_temp_index (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // whole-degree temperature in
    input  wire logic       load,
    input  wire logic [7:0] temp_whole,
    // look-up index out
    output logic      [7:0] idx_q
);
    logic signed [8:0] t;
    logic        [8:0] ofs;
    logic        [7:0] idx_d;

    always_comb begin
        t     = $signed({temp_whole[7], temp_whole});
        ofs   = 9'(t - mmap_pkg::TEMP_MIN_C);
        idx_d = mmap_pkg::LUT_FIRST + {1'b0, ofs[7:1]};
        // clamp both ends of the 2 degree ladder
        if (t < mmap_pkg::TEMP_MIN_C) begin
            idx_d = mmap_pkg::LUT_FIRST;
        end else if (t > mmap_pkg::TEMP_MAX_C) begin
            idx_d = mmap_pkg::LUT_LAST;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idx_q <= mmap_pkg::LUT_FIRST;
        end else if (load) begin
            idx_q <= idx_d;
        end
    end
endmodule
`default_nettype wire

// file: core/mmap_top.sv
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`default_nettype none
// Operation
// - vcc result unsigned, 100 uV per count
// - monitor results unsigned, 38.147 uV per count
// - temperature two's complement, 1/256 degree steps
// - index 80h..C7h in 2 degree steps, clamped
// - resistor positions read from indexed table entry
// - manual mode takes table 01 bytes 82h/83h
// - aux at A0h, main A2h or programmed
// - single-address select hides the auxiliary address
// - single-address mode exposes table 00 memory
// - upper addresses reachable only via main address
// - byte 7Fh selects the upper table
// - aux address denied tables; aux is table
// - main protected when pin and enable set
// - aux protected by its enable alone
// - aux enable also guards table 00
// - writes obey protection; read-only never written
// - programmable main address byte resets to A2h
// - 12 significant bits, left-justified, low nibble zero
// - grounded protect input means main unprotected
module mmap_top #(
    parameter int MEAS_BITS = 12
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // byte engine of the 2-wire front end
    input  wire mmap_pkg::mmap_ser_req_s ser_req,
    output mmap_pkg::mmap_ser_rsp_s    ser_rsp,
    // converter results and protect pin
    input  wire mmap_pkg::mmap_meas_s  meas,
    input  wire logic                  write_protect_input,
    // resistor positions
    output logic      [7:0]            wiper0_q,
    output logic      [7:0]            wiper1_q
);
    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (MEAS_BITS < 1 || MEAS_BITS > 12) begin : g_bad_bits
        $error("MEAS_BITS must lie in 1..12");
    end

    // ****************************************************************
    // storage and derived configuration
    // ****************************************************************
    logic [7:0]  mem_q [mmap_pkg::MEM_BYTES];
    logic [7:0]  cfg;
    logic [7:0]  tsel;
    logic [7:0]  main_addr;
    logic        temp_index_enable;
    logic        single_address_select;
    logic        programmable_main_addr_select;
    logic        main_space_protect_enable;
    logic        aux_space_protect_enable;
    logic        main_prot;
    logic        aux_prot;
    logic [7:0]  lut_idx;
    logic        main_sel_q;
    logic        match_q;
    logic [7:0]  ptr_q;
    logic [10:0] acc;
    logic        acc_ok;
    logic [9:0]  acc_idx;
    logic        wr_allowed;
    logic        ser_wr;
    logic        wb_req;
    logic        wb_wr;

    assign cfg                           = mem_q[mmap_pkg::BASE_T1 + 10'(mmap_pkg::CFG_BYTE)];
    assign tsel                          = mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::TABLE_SEL)];
    assign temp_index_enable             = cfg[mmap_pkg::CFG_TEN];
    assign single_address_select         = cfg[mmap_pkg::CFG_SINGLE_ADDRESS_SELECT];
    assign programmable_main_addr_select = cfg[mmap_pkg::CFG_PROGRAMMABLE_MAIN_ADDR_SELECT];
    assign main_space_protect_enable     = cfg[mmap_pkg::CFG_MAIN_SPACE_PROTECT_ENABLE];
    assign aux_space_protect_enable      = cfg[mmap_pkg::CFG_AUX_SPACE_PROTECT_ENABLE];

    // pin held low leaves main writable; pull-up is a pad matter
    assign main_prot = write_protect_input & main_space_protect_enable;
    assign aux_prot  = aux_space_protect_enable;

    // programmed address byte, used only when selected
    assign main_addr = programmable_main_addr_select
                     ? mem_q[mmap_pkg::BASE_T1 + 10'(mmap_pkg::MAIN_ADDR_BYTE)]
                     : mmap_pkg::MAIN_DEV_ADDR;

    // ****************************************************************
    // address mapping
    // ****************************************************************
    // returns {valid, flat index}; invalid means reads fill, writes drop
    function automatic logic [10:0] map_addr(input logic       to_main,
                                             input logic [7:0] ptr,
                                             input logic [7:0] sel);
        logic [9:0] base;
        logic       ok;
        base = mmap_pkg::BASE_AUX;
        ok   = 1'b1;
        if (!to_main) begin
            // aux address sees only its own 128 bytes
            ok = (ptr < mmap_pkg::UPPER_START);
        end else if (ptr < mmap_pkg::UPPER_START) begin
            base = mmap_pkg::BASE_MAIN;
        end else begin
            // upper window follows byte 7Fh
            case (sel)
                8'h00:   base = mmap_pkg::BASE_AUX;
                8'h01:   base = mmap_pkg::BASE_T1;
                8'h02:   base = mmap_pkg::BASE_T2;
                8'h03:   base = mmap_pkg::BASE_T3;
                default: ok = 1'b0;
            endcase
        end
        return {ok, base + {3'h0, ptr[6:0]}};
    endfunction

    // write permission for one flat location
    function automatic logic may_write(input logic [9:0] idx,
                                       input logic       mprot,
                                       input logic       aprot);
        logic [7:0] lo;
        logic       ok;
        lo = {1'b0, idx[6:0]};
        ok = 1'b1;
        if (idx < mmap_pkg::BASE_MAIN) begin
            ok = !aprot;
        end else if (idx < mmap_pkg::BASE_T1) begin
            if (lo >= mmap_pkg::MEAS_FIRST && lo <= mmap_pkg::MEAS_LAST) begin
                ok = 1'b0;
            end else if (lo >= mmap_pkg::RSVD_FIRST && lo <= mmap_pkg::RSVD_LAST) begin
                ok = 1'b0;
            end else if (lo[6:0] != mmap_pkg::TABLE_SEL) begin
                // table select stays writable so tables can still be read
                ok = !mprot;
            end
        end else begin
            ok = !mprot;
        end
        return ok;
    endfunction

    assign acc     = map_addr(main_sel_q, ptr_q, tsel);
    assign acc_ok  = acc[10];
    assign acc_idx = acc[9:0];
    assign wr_allowed = acc_ok && may_write(acc_idx, main_prot, aux_prot);
    assign ser_wr  = ser_req.valid && match_q && (ser_req.op == mmap_pkg::MMAP_OP_WRITE)
                     && wr_allowed;

    // ****************************************************************
    // 2-wire byte engine side
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            match_q    <= 1'b0;
            main_sel_q <= 1'b0;
        end else if (ser_req.valid && ser_req.op == mmap_pkg::MMAP_OP_ADDR) begin
            // main wins if programmed to the aux value
            if (ser_req.data[7:1] == main_addr[7:1]) begin
                match_q    <= 1'b1;
                main_sel_q <= 1'b1;
            end else if (!single_address_select
                         && ser_req.data[7:1] == mmap_pkg::AUX_DEV_ADDR[7:1]) begin
                match_q    <= 1'b1;
                main_sel_q <= 1'b0;
            end else begin
                match_q    <= 1'b0;
                main_sel_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr_q <= 8'h00;
        end else if (ser_req.valid && match_q) begin
            case (ser_req.op)
                mmap_pkg::MMAP_OP_PTR:   ptr_q <= ser_req.data;
                mmap_pkg::MMAP_OP_WRITE: ptr_q <= ptr_q + 8'h01;
                mmap_pkg::MMAP_OP_READ:  ptr_q <= ptr_q + 8'h01;
                default:                 ptr_q <= ptr_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ser_rsp <= '0;
        end else begin
            ser_rsp.done  <= ser_req.valid;
            ser_rsp.wr_ok <= ser_wr;
            ser_rsp.match <= (ser_req.valid && ser_req.op == mmap_pkg::MMAP_OP_ADDR)
                             ? ((ser_req.data[7:1] == main_addr[7:1])
                                || (!single_address_select
                                    && ser_req.data[7:1] == mmap_pkg::AUX_DEV_ADDR[7:1]))
                             : match_q;
            if (ser_req.valid && match_q && ser_req.op == mmap_pkg::MMAP_OP_READ) begin
                ser_rsp.rdata <= acc_ok ? mem_q[acc_idx] : mmap_pkg::READ_FILL;
            end
        end
    end

    // ****************************************************************
    // storage writes: converter results, serial bytes, wishbone config
    // ****************************************************************
    // left-justify a result, low bits forced to zero
    function automatic logic [15:0] justify(input logic [11:0] code);
        logic [15:0] v;
        v = {code, 4'h0};
        v = v & ~16'((16'h1 << (16 - MEAS_BITS)) - 16'h1);
        return v;
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < mmap_pkg::MEM_BYTES; i++) begin
                mem_q[i] <= 8'h00;
            end
            mem_q[mmap_pkg::BASE_T1 + 10'(mmap_pkg::CFG_BYTE)]       <= mmap_pkg::CFG_RESET;
            mem_q[mmap_pkg::BASE_T1 + 10'(mmap_pkg::MAIN_ADDR_BYTE)] <= mmap_pkg::MAIN_DEV_ADDR;
        end else begin
            if (meas.valid) begin
                // most significant byte at the lower address
                {mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::MEAS_TEMP)],
                 mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::MEAS_TEMP) + 10'h1]}  <= justify(meas.temp);
                {mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::MEAS_VCC)],
                 mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::MEAS_VCC) + 10'h1]}   <= justify(meas.vcc);
                {mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::MEAS_MON_A)],
                 mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::MEAS_MON_A) + 10'h1]} <= justify(meas.mon_a);
                {mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::MEAS_MON_B)],
                 mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::MEAS_MON_B) + 10'h1]} <= justify(meas.mon_b);
                {mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::MEAS_MON_C)],
                 mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::MEAS_MON_C) + 10'h1]} <= justify(meas.mon_c);
            end
            if (ser_wr) begin
                mem_q[acc_idx] <= ser_req.data;
            end
            // local software bypasses the serial protection scheme
            if (wb_wr && wb_adr_i == mmap_pkg::WB_CONFIG && wb_sel_i[0]) begin
                mem_q[mmap_pkg::BASE_T1 + 10'(mmap_pkg::CFG_BYTE)] <=
                    wb_dat_i[7:0] & mmap_pkg::CFG_MASK;
            end
        end
    end

    // ****************************************************************
    // temperature index and resistor positions
    // ****************************************************************
    logic [7:0] temp_hi;
    logic [9:0] lut_ofs;

    // whole degrees sit in the high byte of the stored result
    assign temp_hi = mem_q[mmap_pkg::BASE_MAIN + 10'(mmap_pkg::MEAS_TEMP)];
    assign lut_ofs = {3'h0, lut_idx[6:0]};

    mmap_temp_index u_index (
        .clk        (clk),
        .rst_n      (rst_n),
        .load       (temp_index_enable),
        .temp_whole (temp_hi),
        .idx_q      (lut_idx)
    );

    // both positions move on the same edge, never half-updated
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wiper0_q <= 8'h00;
            wiper1_q <= 8'h00;
        end else if (temp_index_enable) begin
            wiper0_q <= mem_q[mmap_pkg::BASE_T2 + lut_ofs];
            wiper1_q <= mem_q[mmap_pkg::BASE_T3 + lut_ofs];
        end else begin
            wiper0_q <= mem_q[mmap_pkg::BASE_T1 + 10'(mmap_pkg::MAN_WIPER0)];
            wiper1_q <= mem_q[mmap_pkg::BASE_T1 + 10'(mmap_pkg::MAN_WIPER1)];
        end
    end

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    // ack one cycle after the request, dropped the cycle after
    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_wr  = wb_req && wb_we_i && wb_ack_o;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_ack_o) begin
            case (wb_adr_i)
                mmap_pkg::WB_CONFIG: wb_dat_o <= {24'h00_0000, cfg};
                mmap_pkg::WB_STATUS: wb_dat_o <= {6'h00, aux_prot, main_prot,
                                                  wiper1_q, wiper0_q, lut_idx};
                mmap_pkg::WB_ADDRS:  wb_dat_o <= {16'h0000, tsel, main_addr};
                mmap_pkg::WB_TEMP:   wb_dat_o <= {16'h0000, temp_hi,
                                       mem_q[mmap_pkg::BASE_MAIN
                                             + 10'(mmap_pkg::MEAS_TEMP) + 10'h1]};
                default:             wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: dv/mmap_chk.sv
`default_nettype none
module mmap_chk (
    // clock and reset
    input wire logic                    clk,
    input wire logic                    rst_n,
    // watched ports
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [7:0]              wb_adr_i,
    input wire logic [3:0]              wb_sel_i,
    input wire logic [31:0]             wb_dat_i,
    input wire logic                    wb_ack_o,
    input wire mmap_pkg::mmap_ser_req_s ser_req,
    input wire mmap_pkg::mmap_ser_rsp_s ser_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // shadow of config; serial writes to it are not followed
    // ********
    logic [4:0] cfg_q;
    logic       aux_q;
    wire        adr_v = ser_req.valid && ser_req.op == mmap_pkg::MMAP_OP_ADDR;
    wire        wr_v = ser_req.valid && ser_req.op == mmap_pkg::MMAP_OP_WRITE;
    wire        rd_v = ser_req.valid && ser_req.op == mmap_pkg::MMAP_OP_READ;
    wire        a0 = ser_req.data == 8'hA0;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= 5'h01;
        end else if (wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == 8'h00) begin
            cfg_q <= wb_dat_i[4:0];
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aux_q <= 1'b0;
        end else if (adr_v) begin
            aux_q <= a0;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ack_next_a:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    ack_pulse_a:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    done_next_a:
        assert property (ser_req.valid |=> ser_rsp.done) else $error("no done");
    wr_cause_a:
        assert property (ser_rsp.wr_ok |-> $past(wr_v)) else $error("stray wr_ok");
    aux_addr_a:
        assert property (adr_v && a0 && !cfg_q[1] |=> ser_rsp.match) else $error("aux miss");
    single_addr_a:
        assert property (adr_v && a0 && cfg_q[1] && !cfg_q[2] |=> !ser_rsp.match)
        else $error("aux answered");
    main_addr_a:
        assert property (adr_v && ser_req.data == 8'hA2 && !cfg_q[2] |=> ser_rsp.match)
        else $error("main miss");
    aux_prot_a:
        assert property (wr_v && aux_q && cfg_q[4] |=> !ser_rsp.wr_ok)
        else $error("aux write stored");
    rdata_hold_a:
        assert property (!rd_v |=> $stable(ser_rsp.rdata)) else $error("rdata moved");
endmodule
bind mmap_top mmap_chk u_chk (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .ser_req(ser_req), .ser_rsp(ser_rsp));
`default_nettype wire

// file: dv/mmap_host.sv
`default_nettype none
module mmap_host (
    // clock
    input  wire logic                    clk,
    // byte link
    output var mmap_pkg::mmap_ser_req_s  ser_req,
    input  wire mmap_pkg::mmap_ser_rsp_s ser_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // byte requests
    // ********
    mmap_pkg::mmap_ser_rsp_s last;
    initial ser_req = '0;
    // released data is inverted so a stale byte is never mistaken for a live one
    task automatic xfer(input mmap_pkg::mmap_op_e op, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        ser_req <= {1'b1, op, d};
        @(posedge clk);
        ser_req <= {1'b0, op, ~d};
        do begin
            @(posedge clk);
            n++;
        end while (ser_rsp.done !== 1'b1 && n < 20);
        last = ser_rsp;
        if (n == 20) begin
            tb.n_mismatch++;
            tb.final_report();
        end
    endtask
    task automatic go(input logic [7:0] dev, input logic [7:0] p);
        xfer(mmap_pkg::MMAP_OP_ADDR, dev);
        xfer(mmap_pkg::MMAP_OP_PTR, p);
    endtask
    task automatic wr(input logic [7:0] d);
        xfer(mmap_pkg::MMAP_OP_WRITE, d);
    endtask
    task automatic rd();
        xfer(mmap_pkg::MMAP_OP_READ, 8'h00);
    endtask
    task automatic tsel(input logic [7:0] t);
        go(8'hA2, 8'h7F);
        wr(t);
    endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    clk, rst_n, cyc, stb, we, wp, ack;
    logic [7:0]              adr, w0, w1, off;
    logic [3:0]              sel, bsel;
    logic [31:0]             wdat, rdat, got;
    logic [11:0]             codes [5] = '{12'h400, 12'h808, 12'hC00, 12'h123, 12'hFFF};
    logic [15:0]             e16;
    logic [7:0]              pc [3] = '{8'h13, 8'h11, 8'h01};
    logic [7:0]              ti [7] = '{8'h80, 8'h80, 8'h81, 8'h81, 8'h82, 8'hC7, 8'hC7};
    int                      tv [7] = '{-50, -40, -38, -37, -35, 102, 120};
    int                      n_mismatch = 0;
    int                      checks_done = 0;
    mmap_pkg::mmap_ser_req_s req;
    mmap_pkg::mmap_ser_rsp_s rsp;
    mmap_pkg::mmap_meas_s    meas;
    mmap_top DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ser_req(req), .ser_rsp(rsp), .meas(meas), .write_protect_input(wp),
        .wiper0_q(w0), .wiper1_q(w1));
    mmap_host h (.clk(clk), .ser_req(req), .ser_rsp(rsp));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ********
    // bus tasks
    // ********
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, bsel};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        got = rdat;
        {cyc, stb, we} <= 3'b000;
        if (n == 20) begin
            n_mismatch++;
            final_report();
        end
    endtask
    task automatic mset(input logic [59:0] v);
        @(posedge clk);
        meas <= {1'b1, v};
        @(posedge clk);
        meas.valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // ********
    // scenarios
    // ********
    initial begin
        {cyc, stb, we, adr, sel, wdat, wp, meas} = '0;
        bsel = 4'hF;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wb(0, mmap_pkg::WB_ADDRS, 0);
        `CHK("addrs", 16'h00A2, got[15:0])
        wb(0, 8'h10, 0);
        `CHK("unmapped", 32'h0, got)
        // config lives in byte lane 0 only
        bsel = 4'hE;
        wb(1, mmap_pkg::WB_CONFIG, 32'h0);
        bsel = 4'hF;
        wb(0, mmap_pkg::WB_CONFIG, 0);
        `CHK("lane", 8'h01, got[7:0])
        mset({codes[0], codes[1], codes[2], codes[3], codes[4]});
        h.go(8'hA2, 8'h60);
        for (int i = 0; i < 10; i++) begin
            h.rd();
            e16 = {codes[i / 2], 4'h0};
            `CHK("meas", i[0] ? e16[7:0] : e16[15:8], h.last.rdata)
        end
        wb(1, mmap_pkg::WB_CONFIG, 32'h0);
        h.tsel(8'h01);
        h.go(8'hA2, 8'h82);
        h.wr(8'h5A);
        h.wr(8'hA5);
        repeat (3) @(posedge clk);
        `CHK("man0", 8'h5A, w0)
        `CHK("man1", 8'hA5, w1)
        for (int t = 2; t < 4; t++) begin
            h.tsel(8'(t));
            h.go(8'hA2, 8'h80);
            h.wr(8'(t * 16 + 1));
            h.wr(8'(t * 16 + 2));
        end
        wb(1, mmap_pkg::WB_CONFIG, 32'h1);
        foreach (tv[i]) begin
            mset({12'(tv[i] * 16), 48'h0});
            wb(0, mmap_pkg::WB_STATUS, 0);
            off = ti[i] - 8'h80;
            `CHK("index", ti[i], got[7:0])
            `CHK("lut0", off > 1 ? 8'h00 : 8'h21 + off, w0)
            `CHK("lut1", off > 1 ? 8'h00 : 8'h31 + off, w1)
        end
        wb(0, mmap_pkg::WB_TEMP, 0);
        `CHK("temp", 16'h7800, got[15:0])
        wb(1, mmap_pkg::WB_CONFIG, 32'h3);
        h.go(8'hA0, 8'h00);
        `CHK("aux off", 1'b0, h.last.match)
        h.tsel(8'h00);
        h.go(8'hA2, 8'h80);
        h.wr(8'h77);
        h.go(8'hA2, 8'h80);
        h.rd();
        `CHK("tbl00", 8'h77, h.last.rdata)
        foreach (pc[i]) begin
            wb(1, mmap_pkg::WB_CONFIG, {24'h0, pc[i]});
            h.go(8'hA2, 8'h81);
            h.wr(8'h66);
            `CHK("tbl00 wr", pc[i] == 8'h01, h.last.wr_ok)
        end
        h.go(8'hA0, 8'h01);
        h.rd();
        `CHK("aux view", 8'h66, h.last.rdata)
        h.tsel(8'h01);
        h.go(8'hA2, 8'h8C);
        h.wr(8'hB4);
        wb(1, mmap_pkg::WB_CONFIG, 32'h5);
        h.go(8'hB4, 8'h00);
        `CHK("prog", 1'b1, h.last.match)
        h.go(8'hA2, 8'h00);
        `CHK("fixed", 1'b0, h.last.match)
        wb(1, mmap_pkg::WB_CONFIG, 32'h1);
        h.go(8'hA0, 8'h80);
        h.wr(8'h55);
        `CHK("aux hi wr", 1'b0, h.last.wr_ok)
        h.go(8'hA0, 8'h80);
        h.rd();
        `CHK("aux hi rd", 8'hFF, h.last.rdata)
        for (int i = 0; i < 8; i++) begin
            wb(1, mmap_pkg::WB_CONFIG, {27'h0, i[1], i[2], 3'h1});
            wp <= i[0];
            h.go(8'hA0, 8'h10);
            h.wr(8'h55);
            `CHK("aux prot", !i[1], h.last.wr_ok)
            h.go(8'hA2, 8'h38);
            h.wr(8'h3C);
            `CHK("main prot", !(i[0] && i[2]), h.last.wr_ok)
            wb(0, mmap_pkg::WB_STATUS, 0);
            `CHK("prot bits", {i[1], i[0] && i[2]}, got[25:24])
        end
        wb(1, mmap_pkg::WB_CONFIG, 32'h1);
        h.go(8'hA2, 8'h37);
        h.wr(8'h01);
        `CHK("reserved", 1'b0, h.last.wr_ok)
        h.wr(8'h01);
        `CHK("next ptr", 1'b1, h.last.wr_ok)
        h.go(8'hA2, 8'h60);
        h.wr(8'h01);
        `CHK("read only", 1'b0, h.last.wr_ok)
        final_report();
    end
endmodule
`default_nettype wire
